// ===== rtl/cs_decode_pkg.sv
// Package with register offsets, field layouts, reset values and timing counts of the chip-select decoder.
package cs_decode_pkg;
    localparam int          bank_count_c     = 4;
    // Register indices in the register window; each bank owns a base and an option word.
    localparam logic [4:0]  base_off_c       = 5'h00;   // Bank n base at base_off_c + 2n.
    localparam logic [4:0]  option_off_c     = 5'h01;   // Bank n options at option_off_c + 2n.
    localparam logic [4:0]  control_off_c    = 5'h08;
    localparam logic [4:0]  status_off_c     = 5'h09;
    localparam logic [4:0]  reset_vec_off_c  = 5'h0a;
    // Base register fields.
    localparam int          base_valid_bit_c = 0;
    localparam int          base_width_lsb_c = 2;       // Set for a 16-bit port.
    localparam int          base_ext_ta_bit_c = 11;
    localparam int          addr_msb_c       = 31;
    localparam int          addr_lsb_c       = 15;
    // Option register fields.
    localparam int          opt_wait_lsb_c   = 4;
    localparam int          opt_wait_w_c     = 4;
    localparam logic [3:0]  wait_ext_ta_c    = 4'hf;    // External acknowledge terminates.
    localparam int          opt_async_bit_c  = 8;       // Unused in timing; stored only.
    // Control register fields.
    localparam int          ctl_nvm_en_bit_c = 0;
    localparam logic [31:0] base_reset_c     = 32'h0000_0000;
    localparam logic [31:0] option_reset_c   = 32'h0000_0000;
    localparam logic [31:0] control_reset_c  = 32'h0000_0001;
    // Reset vectors selected by the vector prefix strap.
    localparam logic [31:0] vec_low_c        = 32'h0000_0100;
    localparam logic [31:0] vec_high_c       = 32'hfff0_0100;
    // Internal nonvolatile array geometry.
    localparam logic [31:0] nvm_base_c       = 32'h0000_0000;
    localparam int          nvm_block_bytes_c = 65536;
    localparam int          nvm_blocks_c     = 8;
    localparam int          nvm_addr_w_c     = 19;      // 512 Kbytes.
    localparam logic [31:0] nvm_ctl_base_c   = 32'h002f_c000;
    localparam logic [31:0] nvm_ctl_mask_c   = 32'hffff_c000;
    typedef enum logic [2:0] {
        cyc_idle_s = 3'b001,
        cyc_wait_s = 3'b010,
        cyc_ta_s   = 3'b100
    } cyc_state_t;
endpackage

// ===== rtl/cs_bank_if.sv
// Interface carrying one bank's programming and match result between decoder modules.
`timescale 1ns/1ps
interface cs_bank_if;
    logic [31:0] base;
    logic [31:0] option;
    logic [31:0] addr;
    logic        hit;
    modport ctrl (output base, output option, output addr, input hit);
    modport match (input base, input option, input addr, output hit);
endinterface

// ===== rtl/cs_bank_match.sv
// Address comparator of one chip-select bank.
`timescale 1ns/1ps
module cs_bank_match
    import cs_decode_pkg::*;
(
    cs_bank_if.match bank
);
    wire [addr_msb_c:addr_lsb_c] diff_w;
    wire                         valid_w;

    // Only address bits enabled by the option mask take part in the compare.
    assign diff_w = (bank.addr[addr_msb_c:addr_lsb_c] ^ bank.base[addr_msb_c:addr_lsb_c])
                    & bank.option[addr_msb_c:addr_lsb_c];
    assign valid_w = bank.base[base_valid_bit_c];
    assign bank.hit = valid_w && (diff_w == '0);
endmodule

// ===== rtl/cs_decoder.sv
// Four-bank chip-select decoder with boot select, reset vector and internal flash gate.
//
// Functional notes
// - Clearing the internal flash enable hides the array and its control registers.
// - Internal array is 512 Kbytes as eight 64 Kbyte blocks.
// - Four programmable regions each drive their own active-low chip select.
// - Chip select zero doubles as the global boot select.
// - Reset vector is 0x0000_0100 or 0xFFF0_0100 by the prefix strap.
// - After reset chip select zero matches every access outside the internal flash until its options are written.
// - Boot flash first answers at 0xFFF0_0000, later moved to 0x0080_0000.
// - SRAM option 0xFFF0_0000 decodes 1 MB, zero waits, mirrors four times.
// - Flash option 0xFFE0_0030 decodes 2 MB with three wait states.
// - Peripheral base 0x0100_0807 gives a 16-bit port ended by external acknowledge.
// - Peripheral option 0xFFFF_80F0 selects 32 KB and waits for external acknowledge.
`timescale 1ns/1ps
module cs_decoder
    import cs_decode_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        vector_prefix_select,
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        transfer_acknowledge_n,
    output logic      [3:0]  cs_n,
    output logic             acc_done,
    output logic             nvm_array_sel,
    output logic             nvm_ctl_sel,
    output logic      [2:0]  nvm_block,
    output logic      [31:0] reset_vector,
    output logic             port_16bit
);
    logic [31:0] base_q   [bank_count_c];
    logic [31:0] option_q [bank_count_c];
    logic [31:0] control_q;
    logic        boot_global_q;
    logic [31:0] reg_rdata_q;
    logic [3:0]  cs_n_q;
    logic        acc_done_q;
    logic        nvm_array_q;
    logic        nvm_ctl_q;
    logic [2:0]  nvm_block_q;
    logic [31:0] reset_vector_q;
    logic        port16_q;
    logic        prefix_s1_q;
    logic        prefix_s2_q;
    logic        ta_s1_q;
    logic        ta_s2_q;
    logic        vec_caught_q;
    logic [1:0]  sync_full_q;
    logic        ta_ready_q;
    logic [3:0]  wait_cnt_q;
    logic [3:0]  wait_cnt_d;
    logic [3:0]  cs_d;
    cyc_state_t  state_q;
    cyc_state_t  state_d;
    logic        done_d;

    wire  [3:0]  hit_w;
    wire  [3:0]  sel_w;
    wire         nvm_en_w;
    wire         nvm_arr_hit_w;
    wire         nvm_ctl_hit_w;
    wire         int_hit_w;
    wire  [1:0]  bank_w;
    wire  [3:0]  bank_wait_w;
    wire         bank_ext_ta_w;
    wire         ta_seen_w;
    wire  [31:0] rd_mux_w;
    wire  [1:0]  reg_bank_w;
    wire         bank_reg_w;

    genvar g;
    generate
        for (g = 0; g < bank_count_c; g++) begin : g_bank
            cs_bank_if bif ();
            assign bif.base   = base_q[g];
            assign bif.option = option_q[g];
            assign bif.addr   = acc_addr;
            cs_bank_match u_match (
                .bank (bif.match)
            );
            assign hit_w[g] = bif.hit;
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    base_q[g]   <= base_reset_c;
                    option_q[g] <= option_reset_c;
                end else if (reg_wr && bank_reg_w && reg_bank_w == g) begin
                    if (reg_addr[0] == base_off_c[0]) begin
                        base_q[g] <= reg_wdata;
                    end else begin
                        option_q[g] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // Register decode.
    assign bank_reg_w = (reg_addr < control_off_c);
    assign reg_bank_w = reg_addr[2:1];

    // Internal resources win over external banks; they vanish when the array is disabled.
    assign nvm_en_w      = control_q[ctl_nvm_en_bit_c];
    assign nvm_arr_hit_w = nvm_en_w && (acc_addr[31:nvm_addr_w_c] == nvm_base_c[31:nvm_addr_w_c]);
    assign nvm_ctl_hit_w = nvm_en_w && ((acc_addr & nvm_ctl_mask_c) == nvm_ctl_base_c);
    assign int_hit_w     = nvm_arr_hit_w || nvm_ctl_hit_w;

    // While the boot select is armed, bank zero takes every access not claimed by the internal flash and the others stay idle,
    // which is how the boot flash answers at the high vector region before relocation.
    assign sel_w = int_hit_w     ? 4'h0 :
                   boot_global_q ? 4'h1 :
                   hit_w[0]      ? 4'h1 :
                   hit_w[1]      ? 4'h2 :
                   hit_w[2]      ? 4'h4 :
                   hit_w[3]      ? 4'h8 : 4'h0;
    assign bank_w = sel_w[3] ? 2'd3 : sel_w[2] ? 2'd2 : sel_w[1] ? 2'd1 : 2'd0;
    // Boot select uses the slowest programmed wait count so an unprogrammed flash still works.
    assign bank_wait_w   = boot_global_q ? wait_ext_ta_c - 4'h1
                           : option_q[bank_w][opt_wait_lsb_c +: opt_wait_w_c];
    assign bank_ext_ta_w = !boot_global_q && (base_q[bank_w][base_ext_ta_bit_c]
                           || bank_wait_w == wait_ext_ta_c);
    // The acknowledge of the previous cycle is still low in the synchroniser for a few
    // clocks after its select drops, so it only counts once it has been seen released.
    assign ta_seen_w     = ta_ready_q && !ta_s2_q;

    assign rd_mux_w = bank_reg_w ? (reg_addr[0] ? option_q[reg_bank_w] : base_q[reg_bank_w]) :
                      reg_addr == control_off_c   ? control_q :
                      reg_addr == status_off_c    ? {27'h0, boot_global_q, ~cs_n_q} :
                      reg_addr == reset_vec_off_c ? reset_vector_q : 32'h0000_0000;

    // Access cycle sequencer: counts internal waits or waits for the external acknowledge.
    always_comb begin
        state_d    = state_q;
        wait_cnt_d = wait_cnt_q;
        cs_d       = 4'h0;
        done_d     = 1'b0;
        case (state_q)
            cyc_idle_s: begin
                if (acc_valid && sel_w != 4'h0) begin
                    cs_d       = sel_w;
                    wait_cnt_d = bank_wait_w;
                    if (bank_ext_ta_w) begin
                        state_d = cyc_ta_s;
                    end else if (bank_wait_w == 4'h0) begin
                        done_d = 1'b1;
                    end else begin
                        state_d = cyc_wait_s;
                    end
                end else if (acc_valid) begin
                    done_d = 1'b1;
                end
            end
            cyc_wait_s: begin
                cs_d       = ~cs_n_q;
                wait_cnt_d = wait_cnt_q - 4'h1;
                if (wait_cnt_q == 4'h1) begin
                    done_d  = 1'b1;
                    state_d = cyc_idle_s;
                end
            end
            cyc_ta_s: begin
                cs_d = ~cs_n_q;
                if (ta_seen_w) begin
                    done_d  = 1'b1;
                    state_d = cyc_idle_s;
                end
            end
            default: begin
                state_d = cyc_idle_s;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prefix_s1_q <= 1'b0;
            prefix_s2_q <= 1'b0;
            ta_s1_q     <= 1'b1;
            ta_s2_q     <= 1'b1;
        end else begin
            prefix_s1_q <= vector_prefix_select;
            prefix_s2_q <= prefix_s1_q;
            ta_s1_q     <= transfer_acknowledge_n;
            ta_s2_q     <= ta_s1_q;
        end
    end

    // The strap is caught once, the cycle after the synchroniser has filled.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vec_caught_q   <= 1'b0;
            sync_full_q    <= 2'b00;
            reset_vector_q <= vec_low_c;
        end else begin
            sync_full_q <= {sync_full_q[0], 1'b1};
            if (sync_full_q[1] && !vec_caught_q) begin
                vec_caught_q   <= 1'b1;
                reset_vector_q <= prefix_s2_q ? vec_high_c : vec_low_c;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            control_q     <= control_reset_c;
            boot_global_q <= 1'b1;
            reg_rdata_q   <= 32'h0000_0000;
        end else begin
            if (reg_wr && reg_addr == control_off_c) begin
                control_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == option_off_c) begin
                boot_global_q <= 1'b0;
            end
            reg_rdata_q <= reg_rd ? rd_mux_w : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= cyc_idle_s;
            wait_cnt_q  <= 4'h0;
            cs_n_q      <= 4'hf;
            acc_done_q  <= 1'b0;
            nvm_array_q <= 1'b0;
            nvm_ctl_q   <= 1'b0;
            nvm_block_q <= 3'h0;
            port16_q    <= 1'b0;
            ta_ready_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            wait_cnt_q  <= wait_cnt_d;
            cs_n_q      <= ~cs_d;
            acc_done_q  <= done_d;
            nvm_array_q <= acc_valid && nvm_arr_hit_w;
            nvm_ctl_q   <= acc_valid && nvm_ctl_hit_w;
            nvm_block_q <= acc_addr[nvm_addr_w_c-1 -: 3];
            port16_q    <= acc_valid && sel_w != 4'h0 && base_q[bank_w][base_width_lsb_c];
            ta_ready_q  <= state_q == cyc_ta_s && (ta_ready_q || ta_s2_q);
        end
    end

    assign reg_rdata     = reg_rdata_q;
    assign cs_n          = cs_n_q;
    assign acc_done      = acc_done_q;
    assign nvm_array_sel = nvm_array_q;
    assign nvm_ctl_sel   = nvm_ctl_q;
    assign nvm_block     = nvm_block_q;
    assign reset_vector  = reset_vector_q;
    assign port_16bit    = port16_q;

    boot_select_a: assert property (@(posedge mclk) disable iff (!arst_n)
        boot_global_q && acc_valid && !int_hit_w && state_q == cyc_idle_s
        |=> !cs_n_q[0] && cs_n_q[3:1] == 3'h7)
        else $error("Boot select did not take the access.");
    boot_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_wr && reg_addr == option_off_c |=> !boot_global_q)
        else $error("Boot select stayed armed after option write.");
    nvm_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !nvm_en_w |=> !nvm_array_q && !nvm_ctl_q)
        else $error("Internal flash reachable while disabled.");
    one_select_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $onehot0(~cs_n_q))
        else $error("More than one chip select asserted.");
    zero_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == cyc_idle_s && done_d && cs_d != 4'h0 |=> acc_done_q && state_q == cyc_idle_s)
        else $error("Zero wait access did not finish at once.");
    wait_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == cyc_idle_s && state_d == cyc_wait_s && wait_cnt_d == 4'h3
        |=> !acc_done_q ##1 !acc_done_q ##1 !acc_done_q ##1 acc_done_q)
        else $error("Three wait states not honoured.");
    ext_ta_a: assert property (@(posedge mclk) disable iff (!arst_n)
        state_q == cyc_ta_s && (ta_s2_q || !ta_ready_q) |=> !acc_done_q)
        else $error("External acknowledge cycle ended without acknowledge.");
    vector_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(vec_caught_q) |-> reset_vector_q == ($past(prefix_s2_q) ? vec_high_c : vec_low_c))
        else $error("Reset vector does not follow the strap.");
    vector_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        vec_caught_q |=> $stable(reset_vector_q))
        else $error("Reset vector changed after it was caught.");
endmodule

// ===== verification/ack_responder.sv
// Model of the memory-mapped peripheral that ends its cycles with an external acknowledge.
`timescale 1ns/1ps
module ack_responder (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       sel_n,
    input  wire logic [3:0] ack_delay,
    output logic            ack_n
);
    logic [3:0] cnt_q;

    // The acknowledge line has a pull-up, so a released line reads high.
    // The peripheral answers only while selected; a slow device raises ack_delay.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
            ack_n <= 1'b1;
        end else if (sel_n) begin
            cnt_q <= 4'h0;
            ack_n <= 1'b1;
        end else if (cnt_q == ack_delay) begin
            ack_n <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// ===== verification/chip_select_boot_decoder_test.sv
// Self-checking bench for the chip-select decoder with boot select and reset vector.
`timescale 1ns/1ps
module chip_select_boot_decoder_test;
    import cs_decode_pkg::*;
    logic        mclk, arst_n, reg_wr, reg_rd, prefix, acc_valid, ack_n;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata, acc_addr, rd_q;
    logic [3:0]  ack_delay, acc_cs;
    logic [2:0]  acc_blk;
    logic        acc_nvm, acc_ctl, acc_p16;
    wire  [31:0] reg_rdata, reset_vector;
    wire  [3:0]  cs_n;
    wire  [2:0]  nvm_block;
    wire         acc_done, nvm_array_sel, nvm_ctl_sel, port_16bit;
    int          miscompares, cmp_count, acc_n, i;
    logic [31:0] prog_val [6]  = '{32'hfff0_0003, 32'hfff0_0000, 32'h0080_0003,
                                   32'hffe0_0030, 32'h0100_0807, 32'hffff_80f0};
    logic [4:0]  prog_idx [6]  = '{5'h02, 5'h03, 5'h00, 5'h01, 5'h06, 5'h07};
    logic [31:0] map_addr [7]  = '{32'hfff0_0000, 32'hfff7_fffc, 32'hffe0_0000, 32'h0080_0000,
                                   32'h009f_fffc, 32'h00a0_0000, 32'h0100_8000};
    logic [3:0]  map_cs   [7]  = '{4'hd, 4'hd, 4'hf, 4'he, 4'he, 4'hf, 4'hf};
    int          map_wait [7]  = '{0, 0, 0, 3, 3, 0, 0};

    cs_decoder u_cs_decoder (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .vector_prefix_select(prefix), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .transfer_acknowledge_n(ack_n), .cs_n(cs_n), .acc_done(acc_done),
        .nvm_array_sel(nvm_array_sel), .nvm_ctl_sel(nvm_ctl_sel), .nvm_block(nvm_block),
        .reset_vector(reset_vector), .port_16bit(port_16bit));
    ack_responder u_ack_responder (.mclk(mclk), .arst_n(arst_n), .sel_n(cs_n[3]),
        .ack_delay(ack_delay), .ack_n(ack_n));

    always #25 mclk = ~mclk;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_reg(input logic [4:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask

    task automatic access(input logic [31:0] a);
        acc_nvm = 1'b0; acc_ctl = 1'b0; acc_p16 = 1'b0; acc_blk = 3'h0;
        @(posedge mclk);
        acc_valid <= 1'b1; acc_addr <= a;
        @(posedge mclk);
        acc_valid <= 1'b0;
        #1 acc_cs = cs_n;
        for (acc_n = 0; acc_n < 40; acc_n++) begin
            acc_ctl |= (nvm_ctl_sel === 1'b1);
            acc_p16 |= (port_16bit === 1'b1);
            if (nvm_array_sel === 1'b1) begin
                acc_nvm = 1'b1; acc_blk = nvm_block;
            end
            if (acc_done === 1'b1) break;
            @(posedge mclk);
            #1;
        end
        if (acc_n == 40) begin
            miscompares++;
            $display("MISMATCH acc_done expected 1 seen 0");
            summarize();
        end
    endtask

    task automatic do_reset(input logic p);
        arst_n <= 1'b0; prefix <= p;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    initial begin
        mclk = 0; arst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 5'h00; reg_wdata = 32'h0;
        prefix = 0; acc_valid = 0; acc_addr = 32'h0; ack_delay = 4'h2;
        miscompares = 0; cmp_count = 0;
        do_reset(1'b0);
        check("reset_vector", reset_vector, vec_low_c);
        rd_reg(5'h0a); check("vector reg", rd_q, 32'h0000_0100);
        rd_reg(5'h08); check("control reset", rd_q, control_reset_c);
        rd_reg(5'h00); check("base reset", rd_q, base_reset_c);
        rd_reg(5'h09); check("boot armed", rd_q & 32'h10, 32'h10);
        wr_reg(5'h0b, 32'hffff_ffff);
        rd_reg(5'h0b); check("unmapped", rd_q, 32'h0);
        $display("test reset done");
        access(32'hfff0_0000); check("boot cs", acc_cs, 4'he);
        check("boot waits", acc_n, 14);
        access(32'h1234_5670); check("boot any cs", acc_cs, 4'he);
        $display("test boot select done");
        for (i = 0; i < 6; i++) wr_reg(prog_idx[i], prog_val[i]);
        for (i = 0; i < 6; i++) begin
            rd_reg(prog_idx[i]); check("readback", rd_q, prog_val[i]);
        end
        rd_reg(5'h09); check("boot released", rd_q & 32'h10, 32'h0);
        for (i = 0; i < 7; i++) begin
            access(map_addr[i]); check("map cs", acc_cs, map_cs[i]);
            check("map waits", acc_n, map_wait[i]);
            check("map 16bit", acc_p16, 1'b0);
        end
        $display("test address map done");
        for (i = 0; i < 2; i++) begin
            ack_delay <= (i == 0) ? 4'h2 : 4'h9;
            access(32'h0100_7ffc); check("periph cs", acc_cs, 4'h7);
            check("periph 16bit", acc_p16, 1'b1);
            check("ext ack wait", acc_n, ack_delay + 4);
        end
        $display("test external acknowledge done");
        access(32'h0000_1000); check("nvm hit", {acc_nvm, acc_cs}, 5'h1f);
        check("nvm block", acc_blk, 3'h0);
        access(32'h0007_0000); check("nvm block 7", acc_blk, 3'h7);
        access(32'h002f_c000); check("nvm ctl", acc_ctl, 1'b1);
        wr_reg(5'h08, 32'h0);
        access(32'h0000_1000); check("nvm off", {acc_nvm, acc_cs}, 5'h0f);
        access(32'h002f_c000); check("nvm ctl off", acc_ctl, 1'b0);
        $display("test internal flash done");
        do_reset(1'b1);
        check("reset_vector high", reset_vector, vec_high_c);
        rd_reg(5'h09); check("boot rearmed", rd_q & 32'h10, 32'h10);
        rd_reg(5'h01); check("option reset", rd_q, option_reset_c);
        $display("test second reset done");
        summarize();
    end
endmodule
